// ===== aseb_map.vh
/*
 * Constants for the sized asynchronous external bus master:
 * encodings, status codes and request word fields.
 * Assumes one core clock per bus half clock.
 */
`ifndef ASEB_MAP_VH
`define ASEB_MAP_VH

// Transfer size encoding, also the bytes still to move
`define ASEB_SIZE_BYTE   2'h1
`define ASEB_SIZE_WORD   2'h2
`define ASEB_SIZE_3BYTE  2'h3
`define ASEB_SIZE_LONG   2'h0

// Address space codes
`define ASEB_FC_USER_DATA 3'h1
`define ASEB_FC_USER_PROG 3'h2
`define ASEB_FC_SUPV_DATA 3'h5
`define ASEB_FC_SUPV_PROG 3'h6
`define ASEB_FC_CPU       3'h7

// Completion status of one operand
`define ASEB_ST_OK        2'h0
`define ASEB_ST_BUS_ERR   2'h1
`define ASEB_ST_AUTOVEC   2'h2
`define ASEB_ST_MISALIGN  2'h3

// Request word field positions
`define ASEB_F_WDATA_LSB  0
`define ASEB_F_ADDR_LSB   32
`define ASEB_F_SIZE_LSB   56
`define ASEB_F_FC_LSB     58
`define ASEB_F_RW         61
`define ASEB_F_LOCK_LAST  62
`define ASEB_F_LOCK       63
`define ASEB_REQ_W        64

`endif

// ===== aseb_sync.v
/*
 * Two-stage synchroniser for a group of bus inputs.
 * Assumes inputs are asynchronous pins; reset value is a parameter.
 */
`timescale 1ns/1ns
module aseb_sync
#(
    parameter WIDTH   = 1,
    parameter RST_VAL = 0
)
(
    // Clock and reset
    input  wire             i_clk,
    input  wire             i_rst_n,
    // Pins and resolved levels
    input  wire [WIDTH-1:0] i_pin,
    output wire [WIDTH-1:0] o_level
);

reg [WIDTH-1:0] meta_reg;
reg [WIDTH-1:0] level_reg;

// The first stage feeds only the second; it may go metastable
always @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        meta_reg  <= RST_VAL;
        level_reg <= RST_VAL;
    end
    else
    begin
        meta_reg  <= i_pin;
        level_reg <= meta_reg;
    end
end

assign o_level = level_reg;

endmodule // aseb_sync

// ===== aseb_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock; both flags come from flops.
 */
`timescale 1ns/1ns
module aseb_fifo
#(
    parameter WIDTH = 64,
    parameter DEPTH = 8,
    parameter AW    = 3
)
(
    // Clock and reset
    input  wire             i_clk,
    input  wire             i_rst_n,
    // Fill side
    input  wire             i_in_valid,
    output wire             o_in_ready,
    input  wire [WIDTH-1:0] i_in_data,
    // Drain side
    output wire             o_out_valid,
    input  wire             i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0]    wr_reg;
reg [AW-1:0]    rd_reg;
reg [AW:0]      cnt_reg;
reg             full_reg;
reg             empty_reg;

wire            push = i_in_valid && !full_reg;
wire            pop  = i_out_ready && !empty_reg;
wire [AW:0]     cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

always @(posedge i_clk)
begin
    if (push)
    begin
        mem[wr_reg] <= i_in_data;
    end
end

always @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        wr_reg    <= {AW{1'b0}};
        rd_reg    <= {AW{1'b0}};
        cnt_reg   <= {(AW+1){1'b0}};
        full_reg  <= 1'b0;
        empty_reg <= 1'b1;
    end
    else
    begin
        if (push)
        begin
            wr_reg <= (wr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_reg + 1'b1;
        end
        if (pop)
        begin
            rd_reg <= (rd_reg == DEPTH - 1) ? {AW{1'b0}} : rd_reg + 1'b1;
        end
        cnt_reg   <= cnt_next;
        full_reg  <= (cnt_next == DEPTH);
        empty_reg <= (cnt_next == {(AW+1){1'b0}});
    end
end

assign o_in_ready  = !full_reg;
assign o_out_valid = !empty_reg;
assign o_out_data  = mem[rd_reg];

endmodule // aseb_fifo

// ===== aseb_bus_master.v
/*
 * Sized asynchronous external bus master: takes operand requests from
 * a FIFO and runs byte/word bus cycles to 8- or 16-bit slaves.
 * Assumes the bus pins are asynchronous; the pin pad resolves the
 * data output enable into the shared data wires.
 */
`timescale 1ns/1ns
`include "aseb_map.vh"

// Overview of operation
// - Size outputs show bytes still to move
// - Address, size, space, direction held during strobe
// - Direction changes only at cycle start
// - Lock output spans whole read-modify-write operation
// - Three space code bits select eight spaces
// - 24-bit address names most significant byte
// - Address strobe half clock after start
// - Read data captured at cycle's last sample
// - Writes drive all sixteen data lines
// - Write data half clock after address strobe
// - Read data strobe with address strobe
// - Write data strobe full clock after address strobe
// - Bus fault ends cycle as error
// - Fault plus halt means retry cycle
// - Autovector only ends interrupt acknowledge
// - All bus inputs synchronised before use
// - Word and long operands must be even
// - Split operand over narrow or odd port
// - Port width learned anew each cycle
// - Acknowledge code: wait, 8-bit, 16-bit, reserved
module aseb_bus_master
#(
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW    = 3
)
(
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst_n,
    // Operand request stream
    input  wire        i_req_valid,
    output wire        o_req_ready,
    input  wire        i_req_read,
    input  wire [1:0]  i_req_size,
    input  wire [2:0]  i_req_space,
    input  wire [23:0] i_req_addr,
    input  wire [31:0] i_req_wdata,
    input  wire        i_req_lock,
    input  wire        i_req_lock_last,
    // Operand completion
    output wire        o_rsp_valid,
    output wire [1:0]  o_rsp_status,
    output wire [31:0] o_rsp_rdata,
    // Bus outputs
    output wire [23:0] o_bus_address,
    output wire        o_xfer_size_hi,
    output wire        o_xfer_size_lo,
    output wire [2:0]  o_space_code,
    output wire        o_read_write,
    output wire        o_addr_strobe_n,
    output wire        o_data_strobe_n,
    output wire        o_locked_sequence_n,
    // Bus data, two-way
    input  wire [15:0] i_bus_data,
    output wire [15:0] o_bus_data,
    output wire        o_bus_data_oe,
    // Termination inputs
    input  wire        i_ack_wide_port_n,
    input  wire        i_ack_narrow_port_n,
    input  wire        i_bus_fault_n,
    input  wire        i_halt_n,
    input  wire        i_auto_vector_n
);

localparam ST_IDLE  = 3'h0;
localparam ST_ADDR  = 3'h1;
localparam ST_STRB  = 3'h2;
localparam ST_WDATA = 3'h3;
localparam ST_WDS   = 3'h4;
localparam ST_WAIT  = 3'h5;
localparam ST_END   = 3'h6;

////////////////////////////////////////////////////////////////////////////////
// Request FIFO and input synchronisers

wire [`ASEB_REQ_W-1:0] req_word;
wire [`ASEB_REQ_W-1:0] f_data;
wire                   f_valid;
wire                   f_ready;
wire [20:0]            pins_s;

assign req_word = {i_req_lock, i_req_lock_last, i_req_read, i_req_space,
                   i_req_size, i_req_addr, i_req_wdata};

aseb_fifo
#(
    .WIDTH (`ASEB_REQ_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
)
u_fifo
(
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (i_req_valid),
    .o_in_ready  (o_req_ready),
    .i_in_data   (req_word),
    .o_out_valid (f_valid),
    .i_out_ready (f_ready),
    .o_out_data  (f_data)
);

// Strobes idle high, data idles low
aseb_sync
#(
    .WIDTH   (21),
    .RST_VAL (21'h1f0000)
)
u_sync
(
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_pin   ({i_ack_wide_port_n, i_ack_narrow_port_n, i_bus_fault_n,
               i_halt_n, i_auto_vector_n, i_bus_data}),
    .o_level (pins_s)
);

wire        wide_s   = !pins_s[20];
wire        narrow_s = !pins_s[19];
wire        fault_s  = !pins_s[18];
wire        halt_s   = !pins_s[17];
wire        auto_vector_n_s   = !pins_s[16];
wire [15:0] data_s   = pins_s[15:0];

////////////////////////////////////////////////////////////////////////////////
// Operand state

reg  [2:0]  state_reg;
reg  [2:0]  rem_reg;
reg  [23:0] addr_reg;
reg  [31:0] wsh_reg;
reg  [31:0] acc_reg;
reg         read_reg;
reg  [2:0]  space_reg;
reg         lock_reg;
reg         lock_last_reg;
reg         done_reg;
reg         retry_reg;
reg  [1:0]  status_reg;

// Pin and response flops
reg  [23:0] bus_addr_reg;
reg  [1:0]  size_out_reg;
reg  [2:0]  space_out_reg;
reg         rw_out_reg;
reg         as_n_reg;
reg         ds_n_reg;
reg         lock_n_reg;
reg  [15:0] wd_reg;
reg         wd_oe_reg;
reg         rsp_valid_reg;
reg  [1:0]  rsp_status_reg;
reg  [31:0] rsp_rdata_reg;

assign f_ready = (state_reg == ST_IDLE);

wire [1:0]  f_size  = f_data[`ASEB_F_SIZE_LSB+1:`ASEB_F_SIZE_LSB];
wire [23:0] f_addr  = f_data[`ASEB_F_ADDR_LSB+23:`ASEB_F_ADDR_LSB];
wire [31:0] f_wdata = f_data[`ASEB_F_WDATA_LSB+31:`ASEB_F_WDATA_LSB];
wire        f_odd   = f_addr[0] && (f_size != `ASEB_SIZE_BYTE);

// Bytes this cycle: one on a narrow port, an odd address or a last byte
wire        one_byte = narrow_s || addr_reg[0] || (rem_reg == 3'h1);
wire [2:0]  moved    = one_byte ? 3'h1 : 3'h2;
wire [7:0]  rd_byte  = (wide_s && addr_reg[0]) ? data_s[7:0] : data_s[15:8];

////////////////////////////////////////////////////////////////////////////////
// Bus cycle sequencer

always @(posedge i_clk or negedge i_rst_n)
begin
    if (!i_rst_n)
    begin
        state_reg      <= ST_IDLE;
        rem_reg        <= 3'h0;
        addr_reg       <= 24'h000000;
        wsh_reg        <= 32'h00000000;
        acc_reg        <= 32'h00000000;
        read_reg       <= 1'b1;
        space_reg      <= 3'h0;
        lock_reg       <= 1'b0;
        lock_last_reg  <= 1'b0;
        done_reg       <= 1'b0;
        retry_reg      <= 1'b0;
        status_reg     <= `ASEB_ST_OK;
        bus_addr_reg   <= 24'h000000;
        size_out_reg   <= 2'h0;
        space_out_reg  <= 3'h0;
        rw_out_reg     <= 1'b1;
        as_n_reg       <= 1'b1;
        ds_n_reg       <= 1'b1;
        lock_n_reg     <= 1'b1;
        wd_reg         <= 16'h0000;
        wd_oe_reg      <= 1'b0;
        rsp_valid_reg  <= 1'b0;
        rsp_status_reg <= `ASEB_ST_OK;
        rsp_rdata_reg  <= 32'h00000000;
    end
    else
    begin
        rsp_valid_reg <= 1'b0;
        case (state_reg)
            ST_IDLE:
            begin
                if (f_valid && f_odd)
                begin
                    // No bus cycle for a misaligned word or long
                    rsp_valid_reg  <= 1'b1;
                    rsp_status_reg <= `ASEB_ST_MISALIGN;
                    rsp_rdata_reg  <= 32'h00000000;
                    if (f_data[`ASEB_F_LOCK_LAST])
                    begin
                        lock_n_reg <= 1'b1;
                    end
                end
                else if (f_valid)
                begin
                    read_reg      <= f_data[`ASEB_F_RW];
                    space_reg     <= f_data[`ASEB_F_FC_LSB+2:`ASEB_F_FC_LSB];
                    lock_reg      <= f_data[`ASEB_F_LOCK];
                    lock_last_reg <= f_data[`ASEB_F_LOCK_LAST];
                    addr_reg      <= f_addr;
                    acc_reg       <= 32'h00000000;
                    status_reg    <= `ASEB_ST_OK;
                    retry_reg     <= 1'b0;
                    done_reg      <= 1'b0;
                    case (f_size)
                        `ASEB_SIZE_BYTE:
                        begin
                            rem_reg <= 3'h1;
                            wsh_reg <= {f_wdata[7:0], 24'h000000};
                        end
                        `ASEB_SIZE_WORD:
                        begin
                            rem_reg <= 3'h2;
                            wsh_reg <= {f_wdata[15:0], 16'h0000};
                        end
                        default:
                        begin
                            rem_reg <= 3'h4;
                            wsh_reg <= f_wdata;
                        end
                    endcase
                    state_reg <= ST_ADDR;
                end
            end
            ST_ADDR:
            begin
                // Cycle start: all qualifiers change here only
                bus_addr_reg  <= addr_reg;
                size_out_reg  <= rem_reg[1:0];
                space_out_reg <= space_reg;
                rw_out_reg    <= read_reg;
                if (lock_reg)
                begin
                    lock_n_reg <= 1'b0;
                end
                state_reg <= ST_STRB;
            end
            ST_STRB:
            begin
                as_n_reg <= 1'b0;
                if (read_reg)
                begin
                    ds_n_reg  <= 1'b0;
                    state_reg <= ST_WAIT;
                end
                else
                begin
                    state_reg <= ST_WDATA;
                end
            end
            ST_WDATA:
            begin
                // Port width is unknown, so both lanes carry data
                wd_oe_reg <= 1'b1;
                if (addr_reg[0] || rem_reg == 3'h1)
                begin
                    wd_reg <= {wsh_reg[31:24], wsh_reg[31:24]};
                end
                else
                begin
                    wd_reg <= wsh_reg[31:16];
                end
                state_reg <= ST_WDS;
            end
            ST_WDS:
            begin
                ds_n_reg  <= 1'b0;
                state_reg <= ST_WAIT;
            end
            ST_WAIT:
            begin
                if (fault_s && halt_s)
                begin
                    retry_reg <= 1'b1;
                    state_reg <= ST_END;
                end
                else if (fault_s || (wide_s && narrow_s))
                begin
                    // Reserved acknowledge code is taken as a fault
                    status_reg <= `ASEB_ST_BUS_ERR;
                    done_reg   <= 1'b1;
                    state_reg  <= ST_END;
                end
                else if (auto_vector_n_s && space_reg == `ASEB_FC_CPU)
                begin
                    status_reg <= `ASEB_ST_AUTOVEC;
                    done_reg   <= 1'b1;
                    state_reg  <= ST_END;
                end
                else if (wide_s || narrow_s)
                begin
                    // Width decided per cycle from the acknowledge
                    if (read_reg)
                    begin
                        if (one_byte)
                        begin
                            acc_reg <= {acc_reg[23:0], rd_byte};
                        end
                        else
                        begin
                            acc_reg <= {acc_reg[15:0], data_s};
                        end
                    end
                    wsh_reg   <= one_byte ? {wsh_reg[23:0], 8'h00} : {wsh_reg[15:0], 16'h0000};
                    addr_reg  <= addr_reg + {21'h000000, moved};
                    rem_reg   <= rem_reg - moved;
                    done_reg  <= (rem_reg == moved);
                    state_reg <= ST_END;
                end
            end
            ST_END:
            begin
                as_n_reg  <= 1'b1;
                ds_n_reg  <= 1'b1;
                wd_oe_reg <= 1'b0;
                // Wait for the slave to release its termination
                if (!wide_s && !narrow_s && !fault_s && !halt_s)
                begin
                    retry_reg <= 1'b0;
                    if (retry_reg)
                    begin
                        state_reg <= ST_ADDR;
                    end
                    else if (done_reg)
                    begin
                        rsp_valid_reg  <= 1'b1;
                        rsp_status_reg <= status_reg;
                        rsp_rdata_reg  <= read_reg ? acc_reg : 32'h00000000;
                        if (lock_last_reg || status_reg != `ASEB_ST_OK || !lock_reg)
                        begin
                            lock_n_reg <= 1'b1;
                        end
                        state_reg <= ST_IDLE;
                    end
                    else
                    begin
                        state_reg <= ST_ADDR;
                    end
                end
            end
            default:
            begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs

assign o_rsp_valid         = rsp_valid_reg;
assign o_rsp_status        = rsp_status_reg;
assign o_rsp_rdata         = rsp_rdata_reg;
assign o_bus_address       = bus_addr_reg;
assign o_xfer_size_hi      = size_out_reg[1];
assign o_xfer_size_lo      = size_out_reg[0];
assign o_space_code        = space_out_reg;
assign o_read_write        = rw_out_reg;
assign o_addr_strobe_n     = as_n_reg;
assign o_data_strobe_n     = ds_n_reg;
assign o_locked_sequence_n = lock_n_reg;
assign o_bus_data          = wd_reg;
assign o_bus_data_oe       = wd_oe_reg;

endmodule // aseb_bus_master

// ===== aseb_assertions.sv
/* Pin-level checker for the bus master: strobe order, hold, sync delay.
   Assumes a bind into aseb_bus_master; async active-low reset. */
`timescale 1ns/1ns
module aseb_assertions
(
    // Clock and reset
    input wire        i_clk,
    input wire        i_rst_n,
    // Bus pins
    input wire [23:0] o_bus_address,
    input wire        o_xfer_size_hi,
    input wire        o_xfer_size_lo,
    input wire [2:0]  o_space_code,
    input wire        o_read_write,
    input wire        o_addr_strobe_n,
    input wire        o_data_strobe_n,
    input wire        o_locked_sequence_n,
    input wire        o_bus_data_oe,
    input wire        i_ack_wide_port_n,
    input wire        i_ack_narrow_port_n,
    // Completion
    input wire        o_rsp_valid,
    input wire [1:0]  o_rsp_status
);
default clocking cb @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
wire [29:0] ctl = {o_bus_address, o_xfer_size_hi, o_xfer_size_lo, o_space_code, o_read_write};
////////////////////////////////////////////////////////////////////////
AST_CTL_HOLD: assert property (!o_addr_strobe_n && $past(!o_addr_strobe_n) |-> $stable(ctl))
    else $error("Control moved");
AST_AS_AFTER_CTL: assert property ($changed(ctl) |-> o_addr_strobe_n ##1 !o_addr_strobe_n)
    else $error("Late address strobe");
AST_RW_AT_START: assert property ($changed(o_read_write) |-> o_addr_strobe_n)
    else $error("Direction moved");
AST_RD_DS: assert property ($fell(o_addr_strobe_n) && o_read_write |-> $fell(o_data_strobe_n))
    else $error("Read strobes apart");
AST_WR_DATA: assert property ($fell(o_addr_strobe_n) && !o_read_write |-> !o_bus_data_oe ##1 o_bus_data_oe)
    else $error("Write data late");
AST_WR_DS: assert property ($fell(o_addr_strobe_n) && !o_read_write
    |-> o_data_strobe_n ##1 o_data_strobe_n ##1 !o_data_strobe_n)
    else $error("Write strobe late");
AST_WR_ALL16: assert property (!o_data_strobe_n && !o_read_write |-> o_bus_data_oe)
    else $error("Write undriven");
AST_LOCK_START: assert property ($fell(o_locked_sequence_n) |-> o_addr_strobe_n ##1 !o_addr_strobe_n)
    else $error("Lock late");
AST_LOCK_END: assert property ($rose(o_locked_sequence_n) |-> o_addr_strobe_n)
    else $error("Lock dropped early");
AST_ODD_SIZE: assert property (!o_addr_strobe_n && o_bus_address[0] |-> o_xfer_size_lo)
    else $error("Odd address size");
AST_STROBE_OFF: assert property ($rose(o_addr_strobe_n) |-> $rose(o_data_strobe_n) && !o_bus_data_oe ##1 o_addr_strobe_n)
    else $error("Strobes not off");
AST_SYNC_DELAY: assert property (!o_addr_strobe_n && ($fell(i_ack_wide_port_n) || $fell(i_ack_narrow_port_n))
    |-> !o_addr_strobe_n ##1 !o_addr_strobe_n ##[1:3] o_addr_strobe_n)
    else $error("Termination timing");
COV_NARROW: cover property (!o_addr_strobe_n && $fell(i_ack_narrow_port_n));
COV_ERROR: cover property (o_rsp_valid && o_rsp_status == 2'h1);
COV_LOCK_WR: cover property (!o_locked_sequence_n && $fell(o_addr_strobe_n) && !o_read_write);
endmodule // aseb_assertions

// ===== aseb_slave_model.sv
/* Slave memory model: 8- or 16-bit port, wait states, faulty endings.
   Assumes the bench muxes the data wires on the master's enable. */
`timescale 1ns/1ns
module aseb_slave_model
(
    // Clock
    input  wire        i_clk,
    // Bus from master
    input  wire        i_as_n,
    input  wire        i_ds_n,
    input  wire        i_rw,
    input  wire [7:0]  i_addr,
    input  wire [1:0]  i_size,
    input  wire [15:0] i_data,
    // Behaviour: port width, wait states, ending 0 ok 1 fault 2 retry 3 autovector
    input  wire        i_narrow,
    input  wire [3:0]  i_wait,
    input  wire [2:0]  i_mode,
    // Terminations and read data
    output reg         o_ack_wide_n   = 1'b1,
    output reg         o_ack_narrow_n = 1'b1,
    output reg         o_fault_n      = 1'b1,
    output reg         o_halt_n       = 1'b1,
    output reg         o_auto_vector_n_n       = 1'b1,
    output reg  [15:0] o_data         = 16'h0
);
reg  [7:0] mem [0:255];
reg  [4:0] cnt      = 5'h0;
reg        rty_done = 1'b0;
wire [7:0] ev       = {i_addr[7:1], 1'b0};
wire [7:0] od       = {i_addr[7:1], 1'b1};
always @(posedge i_clk)
begin
    if (i_as_n)
    begin
        // Idle data toggles so stale bytes never pass
        {o_ack_wide_n, o_ack_narrow_n, o_fault_n, o_halt_n, o_auto_vector_n_n} <= 5'h1f;
        cnt <= 5'h0;
        o_data <= ~o_data;
        if (i_mode != 3'h2)
            rty_done <= 1'b0;
    end
    else if (!i_ds_n)
    begin
        if (cnt != 5'h1f)
            cnt <= cnt + 5'h1;
        if (i_rw)
            o_data <= i_narrow ? {mem[i_addr], ~mem[i_addr]} : {mem[ev], mem[od]};
        if (cnt == {1'b0, i_wait})
        begin
            if (i_mode == 3'h1)
                o_fault_n <= 1'b0;
            else if (i_mode == 3'h2 && !rty_done)
            begin
                o_fault_n <= 1'b0;
                o_halt_n  <= 1'b0;
                rty_done  <= 1'b1;
            end
            else
            begin
                o_ack_narrow_n <= !i_narrow;
                o_ack_wide_n   <= i_narrow;
                o_auto_vector_n_n       <= i_mode != 3'h3;
                if (!i_rw && i_narrow)
                    mem[i_addr] <= i_data[15:8];
                else if (!i_rw && i_addr[0])
                    mem[i_addr] <= i_data[7:0];
                else if (!i_rw)
                begin
                    mem[ev] <= i_data[15:8];
                    if (i_size != 2'h1)
                        mem[od] <= i_data[7:0];
                end
            end
        end
    end
end
endmodule // aseb_slave_model

// ===== aseb_bus_master_bench.sv
/* Self-checking bench: operand requests in, slave model on the bus.
   Assumes a 250 MHz clock. */
`timescale 1ns/1ns
module aseb_bus_master_bench;
reg         clk = 1'b0;
reg         rst_n = 1'b0;
reg         rv = 1'b0;
reg         rd = 1'b0;
reg  [1:0]  sz = 2'h0;
reg  [2:0]  sp = 3'h0;
reg  [23:0] ad = 24'h0;
reg  [31:0] wd = 32'h0;
reg         lk = 1'b0;
reg         ll = 1'b0;
reg         p_narrow = 1'b0;
reg  [3:0]  p_wait = 4'h0;
reg  [2:0]  p_mode = 3'h0;
wire        rdy, rsp_v, sz_hi, sz_lo, rw, as_n, ds_n, lk_n, oe, ackw, ackn, flt, hlt, avn;
wire [1:0]  rsp_st;
wire [31:0] rsp_d;
wire [23:0] b_addr;
wire [2:0]  fc;
wire [15:0] m_do, s_do;
wire [15:0] dbus = oe ? m_do : s_do;
integer     failures = 0;
integer     samples_checked = 0;
integer     rsp_cnt = 0;
integer     cyc = 0;
reg  [15:0] sz_log = 16'h0;
reg  [2:0]  fc_q = 3'h0;
reg  [1:0]  st_q = 2'h0;
reg  [31:0] rd_q = 32'h0;
reg         full_seen = 1'b0;
reg         as_d = 1'b1;
initial
begin
    forever #2 clk = ~clk;
end
aseb_bus_master i_aseb_bus_master (.i_clk(clk), .i_rst_n(rst_n), .i_req_valid(rv), .o_req_ready(rdy),
    .i_req_read(rd), .i_req_size(sz), .i_req_space(sp), .i_req_addr(ad), .i_req_wdata(wd), .i_req_lock(lk),
    .i_req_lock_last(ll), .o_rsp_valid(rsp_v), .o_rsp_status(rsp_st), .o_rsp_rdata(rsp_d),
    .o_bus_address(b_addr), .o_xfer_size_hi(sz_hi), .o_xfer_size_lo(sz_lo), .o_space_code(fc),
    .o_read_write(rw), .o_addr_strobe_n(as_n), .o_data_strobe_n(ds_n), .o_locked_sequence_n(lk_n),
    .i_bus_data(dbus), .o_bus_data(m_do), .o_bus_data_oe(oe), .i_ack_wide_port_n(ackw),
    .i_ack_narrow_port_n(ackn), .i_bus_fault_n(flt), .i_halt_n(hlt), .i_auto_vector_n(avn));
aseb_slave_model i_aseb_slave_model (.i_clk(clk), .i_as_n(as_n), .i_ds_n(ds_n), .i_rw(rw),
    .i_addr(b_addr[7:0]), .i_size({sz_hi, sz_lo}), .i_data(dbus), .i_narrow(p_narrow), .i_wait(p_wait),
    .i_mode(p_mode), .o_ack_wide_n(ackw), .o_ack_narrow_n(ackn), .o_fault_n(flt), .o_halt_n(hlt),
    .o_auto_vector_n_n(avn), .o_data(s_do));
////////////////////////////////////////////////////////////////////////
// Sample on falling edges, off the launch edge
always @(negedge clk)
begin
    as_d <= as_n;
    if (as_d && !as_n)
    begin
        sz_log <= {sz_log[13:0], sz_hi, sz_lo};
        fc_q <= fc;
        cyc <= cyc + 1;
    end
    if (rsp_v === 1'b1)
    begin
        rsp_cnt <= rsp_cnt + 1;
        st_q <= rsp_st;
        rd_q <= rsp_d;
    end
    if (rdy === 1'b0)
        full_seen <= 1'b1;
end
task chk(input [31:0] got, input [31:0] exp);
begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
        failures = failures + 1;
        $display("BAD %0t got %h expected %h", $time, got, exp);
    end
end
endtask
task ctl(input n, input [3:0] w, input [2:0] m);
begin
    @(posedge clk);
    {p_narrow, p_wait, p_mode} <= {n, w, m};
end
endtask
task push(input r, input [1:0] s, input [2:0] p, input [23:0] a, input [31:0] d, input [1:0] l);
begin
    @(posedge clk);
    rv <= 1'b1;
    {rd, sz, sp, ad, wd, lk, ll} <= {r, s, p, a, d, l};
    @(negedge clk);
    while (rdy !== 1'b1)
        @(negedge clk);
    @(posedge clk);
    rv <= 1'b0;
end
endtask
task op(input r, input [1:0] s, input [2:0] p, input [23:0] a, input [31:0] d, input [1:0] l, input [1:0] est);
    integer n, k;
begin
    push(r, s, p, a, d, l);
    n = rsp_cnt;
    for (k = 0; k < 2000 && rsp_cnt == n; k = k + 1)
        @(negedge clk);
    chk(rsp_cnt - n, 32'h1);
    chk({30'h0, st_q}, {30'h0, est});
    if (r && est == 2'h0)
        chk(rd_q, d);
    if (est != 2'h3)
        chk({29'h0, fc_q}, {29'h0, p});
end
endtask
////////////////////////////////////////////////////////////////////////
task t_ports;
    integer n;
begin
    chk({26'h0, as_n, ds_n, lk_n, oe, rdy, rsp_v}, 32'h3a);
    ctl(1'b1, 4'h0, 3'h0);
    op(1'b0, 2'h0, 3'h1, 24'h10, 32'h11223344, 2'h0, 2'h0);
    chk({24'h0, sz_log[7:0]}, 32'h39);
    op(1'b1, 2'h0, 3'h5, 24'h10, 32'h11223344, 2'h0, 2'h0);
    chk({24'h0, sz_log[7:0]}, 32'h39);
    ctl(1'b0, 4'h3, 3'h0);
    op(1'b1, 2'h0, 3'h2, 24'h10, 32'h11223344, 2'h0, 2'h0);
    chk({28'h0, sz_log[3:0]}, 32'h2);
    op(1'b1, 2'h1, 3'h1, 24'h13, 32'h44, 2'h0, 2'h0);
    op(1'b0, 2'h2, 3'h1, 24'h20, 32'ha5b6, 2'h0, 2'h0);
    ctl(1'b1, 4'h0, 3'h0);
    op(1'b1, 2'h1, 3'h1, 24'h21, 32'hb6, 2'h0, 2'h0);
    n = cyc;
    op(1'b1, 2'h2, 3'h1, 24'h31, 32'h0, 2'h0, 2'h3);
    op(1'b0, 2'h0, 3'h1, 24'h33, 32'h0, 2'h0, 2'h3);
    chk(cyc - n, 32'h0);
end
endtask
task t_endings;
    integer n;
begin
    ctl(1'b0, 4'h1, 3'h1);
    op(1'b1, 2'h2, 3'h1, 24'h10, 32'h0, 2'h0, 2'h1);
    ctl(1'b0, 4'h1, 3'h2);
    n = cyc;
    op(1'b0, 2'h1, 3'h6, 24'h40, 32'h5a, 2'h0, 2'h0);
    chk(cyc - n, 32'h2);
    ctl(1'b0, 4'h1, 3'h3);
    op(1'b1, 2'h1, 3'h7, 24'h40, 32'h0, 2'h0, 2'h2);
    op(1'b1, 2'h1, 3'h1, 24'h40, 32'h5a, 2'h0, 2'h0);
    ctl(1'b0, 4'h1, 3'h0);
    op(1'b1, 2'h1, 3'h5, 24'h40, 32'h5a, 2'h2, 2'h0);
    chk({31'h0, lk_n}, 32'h0);
    op(1'b0, 2'h1, 3'h5, 24'h40, 32'h77, 2'h3, 2'h0);
    repeat (3) @(negedge clk);
    chk({31'h0, lk_n}, 32'h1);
end
endtask
task t_fifo;
    integer i, n, k;
begin
    // Slow slave: FIFO fills and refuses
    ctl(1'b0, 4'hf, 3'h0);
    n = rsp_cnt;
    for (i = 0; i < 11; i = i + 1)
        push(1'b0, 2'h1, 3'h1, 24'h60 + i[23:0], 32'h80 + i, 2'h0);
    for (k = 0; k < 5000 && rsp_cnt != n + 11; k = k + 1)
        @(negedge clk);
    chk(rsp_cnt - n, 32'd11);
    chk({31'h0, full_seen}, 32'h1);
    ctl(1'b0, 4'h0, 3'h0);
    op(1'b1, 2'h1, 3'h1, 24'h69, 32'h89, 2'h0, 2'h0);
end
endtask
task tally_and_finish;
begin
    if (failures == 0 && samples_checked > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
end
endtask
initial
begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_ports;
    t_endings;
    t_fifo;
    tally_and_finish;
end
initial
begin
    #100000;
    failures = failures + 1;
    tally_and_finish;
end
endmodule // aseb_bus_master_bench
bind aseb_bus_master aseb_assertions i_aseb_assertions (.*);
